// >>> inc/adcirc_pkg.sv
// adcirc_pkg: register map, field layouts, reset values and carriers of the
// converter control block.
// assumes: included in compile order before every design file.
package adcirc_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int DATA_W   = 8;
  localparam int ADDR_W   = 3;
  localparam int CHAN_W   = 4;
  localparam int SRC_W    = 4;
  localparam int DIV_W    = 3;
  localparam int DIVCNT_W = 7;
  localparam int SAR_BITS = 12;
  localparam int IDX_W    = 4;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CONV   = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_INCLK  = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_REF    = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_BG     = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_RES_HI = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_RES_LO = 3'h5;

  // ----------------------------------------------------------------
  // write masks and reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] CONV_WMASK  = 8'hbf;
  localparam logic [DATA_W-1:0] INCLK_WMASK = 8'hf7;
  localparam logic [DATA_W-1:0] REF_WMASK   = 8'h9f;
  localparam logic [DATA_W-1:0] BG_WMASK    = 8'h01;
  localparam logic [DATA_W-1:0] REG_RST     = 8'h00;

  // result alignment positions
  localparam int RES_HI_L_LSB = 4;
  localparam int RES_HI_R_LSB = 8;
  localparam int RES_LO_L_W   = 4;

  localparam logic [SAR_BITS-1:0] SAR_ZERO = 12'h000;
  localparam logic [IDX_W-1:0]    IDX_MSB  = 4'hb;
  localparam logic [IDX_W-1:0]    IDX_LSB  = 4'h0;

  // ----------------------------------------------------------------
  // register layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              start;
    logic              busy;
    logic              enable;
    logic              align_right;
    logic [CHAN_W-1:0] channel_select;
  } adcirc_conv_s;

  typedef struct packed {
    logic [SRC_W-1:0] input_source_select;
    logic             rsvd;
    logic [DIV_W-1:0] conv_clock_divider;
  } adcirc_inclk_s;

  typedef struct packed {
    logic       ref_amplifier_enable;
    logic [1:0] rsvd;
    logic       amplifier_input_select;
    logic [1:0] reference_source_select;
    logic [1:0] amplifier_gain_select;
  } adcirc_ref_s;

  // ----------------------------------------------------------------
  // analog steering codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_EXT, SRC_AVDD, SRC_AVDD_2, SRC_AVDD_4, SRC_VR, SRC_VR_2, SRC_VR_4, SRC_GND
  } adcirc_src_e;

  typedef enum logic [1:0] {REF_AVDD, REF_PIN, REF_AMP} adcirc_ref_e;

  typedef struct packed {
    logic              power_on;
    logic              ext_chan_connect;
    logic [CHAN_W-1:0] ext_chan;
    adcirc_src_e       source;
    adcirc_ref_e       reference;
    logic              ref_pin_connect;
    logic              amp_enable;
    logic              amp_from_bandgap;
    logic              amp_ext_pin_connect;
    logic [1:0]        amp_gain;
    logic              bandgap_enable;
  } adcirc_ana_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } adcirc_bus_s;

  // ----------------------------------------------------------------
  // decoders
  // ----------------------------------------------------------------
  function automatic adcirc_src_e src_decode(input logic [SRC_W-1:0] code);
    adcirc_src_e r;
    r = SRC_EXT;
    casez (code)
      4'h1:    r = SRC_AVDD;
      4'h2:    r = SRC_AVDD_2;
      4'h3:    r = SRC_AVDD_4;
      4'h5:    r = SRC_VR;
      4'h6:    r = SRC_VR_2;
      4'h7:    r = SRC_VR_4;
      4'b10??: r = SRC_GND;
      default: r = SRC_EXT;
    endcase
    return r;
  endfunction

  function automatic adcirc_ref_e ref_decode(input logic [1:0] code);
    adcirc_ref_e r;
    r = REF_AMP;
    if (code == 2'h0) begin
      r = REF_AVDD;
    end else if (code == 2'h1) begin
      r = REF_PIN;
    end
    return r;
  endfunction

  function automatic logic [DIVCNT_W-1:0] div_limit(input logic [DIV_W-1:0] code);
    logic [DIVCNT_W:0] ratio;
    ratio = (DIVCNT_W+1)'(1) << code;
    return DIVCNT_W'(ratio - (DIVCNT_W+1)'(1));
  endfunction

endpackage

// >>> verilog/adcirc_clkdiv.sv
// adcirc_clkdiv: conversion clock tick generator, divides the system clock.
// assumes: run from the converter sequencer, code held during a conversion.
`timescale 1ns/1ps
`default_nettype none
module adcirc_clkdiv (
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       sys_rst,
  input  wire logic                       clk_en,
  // control
  input  wire logic                       run,
  input  wire logic [adcirc_pkg::DIV_W-1:0] div_code,
  // tick out
  output var  logic                       tick
);
  import adcirc_pkg::*;

  typedef struct packed {
    logic [DIVCNT_W-1:0] cnt;
    logic                tick;
  } adcirc_div_s;

  adcirc_div_s s_reg;
  adcirc_div_s s_next;

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (!run) begin
      s_next.cnt = '0;
    end else if (s_reg.cnt >= div_limit(div_code)) begin
      s_next.cnt  = '0;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + DIVCNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_reg <= '0;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  assign tick = s_reg.tick;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  logic [DIVCNT_W:0] gap_reg;
  logic              gap_ok_reg;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      gap_reg    <= '0;
      gap_ok_reg <= 1'b0;
    end else if (clk_en) begin
      gap_reg    <= s_reg.tick ? '0 : gap_reg + (DIVCNT_W+1)'(1);
      gap_ok_reg <= run && (gap_ok_reg || s_reg.tick) && (div_code == $past(div_code));
    end
  end

  tick_period_a: assert property (clk_en && s_reg.tick && gap_ok_reg && run
      |-> gap_reg == (DIVCNT_W+1)'(div_limit(div_code)))
    else $error("conversion tick spacing differs from divider ratio");

endmodule
`default_nettype wire

// >>> verilog/adcirc_sar.sv
// adcirc_sar: successive approximation sequencer, one sample then 12 trials.
// assumes: comparator high when the input is at or above the trial code.
`timescale 1ns/1ps
`default_nettype none
module adcirc_sar (
  // clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          sys_rst,
  input  wire logic                          clk_en,
  // control
  input  wire logic                          power_on,
  input  wire logic                          start,
  input  wire logic                          tick,
  input  wire logic                          cmp_above,
  // status and result
  output var  logic                          busy,
  output var  logic                          done,
  output var  logic                          sample_hold,
  output var  logic [adcirc_pkg::SAR_BITS-1:0] trial,
  output var  logic [adcirc_pkg::SAR_BITS-1:0] result
);
  import adcirc_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_TRIAL} adcirc_sar_e;

  typedef struct packed {
    adcirc_sar_e         st;
    logic [IDX_W-1:0]    idx;
    logic [SAR_BITS-1:0] trial;
    logic [SAR_BITS-1:0] result;
    logic                busy;
    logic                done;
    logic                sample;
  } adcirc_sarst_s;

  adcirc_sarst_s s_reg;
  adcirc_sarst_s s_next;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    case (s_reg.st)
      ST_IDLE: begin
        if (start && power_on) begin
          s_next.st     = ST_SAMPLE;
          s_next.busy   = 1'b1;
          s_next.sample = 1'b1;
          s_next.trial  = SAR_ZERO;
        end
      end
      ST_SAMPLE: begin
        if (tick) begin
          s_next.st         = ST_TRIAL;
          s_next.sample     = 1'b0;
          s_next.idx        = IDX_MSB;
          s_next.trial      = SAR_ZERO;
          s_next.trial[IDX_MSB] = 1'b1;
        end
      end
      ST_TRIAL: begin
        if (tick) begin
          if (!cmp_above) begin
            s_next.trial[s_reg.idx] = 1'b0;
          end
          if (s_reg.idx == IDX_LSB) begin
            s_next.st     = ST_IDLE;
            s_next.result = s_next.trial;
            s_next.busy   = 1'b0;
            s_next.done   = 1'b1;
          end else begin
            s_next.idx = s_reg.idx - IDX_W'(1);
            s_next.trial[s_next.idx] = 1'b1;
          end
        end
      end
      default: begin
        s_next.st = ST_IDLE;
      end
    endcase
    if (!power_on) begin
      // power down aborts any conversion without a completion
      s_next.st     = ST_IDLE;
      s_next.busy   = 1'b0;
      s_next.done   = 1'b0;
      s_next.sample = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_reg <= '0;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  assign busy        = s_reg.busy;
  assign done        = s_reg.done;
  assign sample_hold = s_reg.sample;
  assign trial       = s_reg.trial;
  assign result      = s_reg.result;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sar_done_clear_a: assert property (s_reg.done |-> !s_reg.busy && !$past(s_reg.done))
    else $error("completion seen while busy still set");

endmodule
`default_nettype wire

// >>> verilog/adcirc_top.sv
// adcirc_top: control logic of a 12-bit successive approximation converter:
// registers, input and reference steering, start sequence and result bytes.
// assumes: byte register port, read data one cycle after the read strobe.
//
// What this block does
// - source codes 0000, 0100 and 11xx route an external channel.
// - other source codes pick supply fractions, amplifier fractions or ground.
// - internal source always disconnects the external channel input.
// - conversion clock is system clock divided by two to the divider code.
// - bit 3 of input and clock select reads zero, ignores writes.
// - bit 7 of reference control enables the reference amplifier.
// - amplifier input from external pin at 0, bandgap at 1.
// - bandgap feeding amplifier disconnects the external amplifier pin.
// - reference field picks supply, external pin, or amplifier output.
// - internal reference disconnects the external reference pin.
// - gain field selects gain 1, 1.667, 2.5 or 3.333.
// - bits 6 and 5 of reference control read zero.
// - bandgap control bit 0 enables bandgap; other bits read zero.
// - writing start high then low with enable set, while idle, begins a conversion.
// - busy flag set once a conversion starts, held while it runs.
// - completion clears busy and pulses the interrupt request.
// - channel select field picks external channel 0 to 15.
`timescale 1ns/1ps
`default_nettype none
module adcirc_top (
  // clock and reset
  input  wire logic                            ref_clk,
  input  wire logic                            sys_rst,
  input  wire logic                            clk_en,
  // register port
  input  wire adcirc_pkg::adcirc_bus_s         bus_req,
  output var  logic [adcirc_pkg::DATA_W-1:0]   rd_data,
  // analog front end
  input  wire logic                            cmp_above,
  output var  adcirc_pkg::adcirc_ana_s         ana_ctrl,
  output var  logic                            sample_hold,
  output var  logic [adcirc_pkg::SAR_BITS-1:0] sar_trial,
  // events
  output var  logic                            conv_int_req
);
  import adcirc_pkg::*;

  typedef struct packed {
    adcirc_conv_s        conv;
    adcirc_inclk_s       inclk;
    adcirc_ref_s         refc;
    logic [DATA_W-1:0]   bg;
    logic                start_pulse;
    logic [DATA_W-1:0]   rdata;
    adcirc_ana_s         ana;
    logic [DATA_W-1:0]   res_hi;
    logic [DATA_W-1:0]   res_lo;
    logic                int_req;
  } adcirc_top_s;

  adcirc_top_s s_reg;
  adcirc_top_s s_next;

  logic                sar_busy;
  logic                sar_done;
  logic [SAR_BITS-1:0] sar_result;
  logic                conv_tick;

  // ----------------------------------------------------------------
  // result alignment
  // ----------------------------------------------------------------
  function automatic logic [2*DATA_W-1:0] align_result(input logic right,
                                                        input logic [SAR_BITS-1:0] r);
    logic [2*DATA_W-1:0] v;
    v = '0;
    if (right) begin
      v[2*DATA_W-1:DATA_W] = DATA_W'(r[SAR_BITS-1:RES_HI_R_LSB]);
      v[DATA_W-1:0]        = r[RES_HI_R_LSB-1:0];
    end else begin
      v[2*DATA_W-1:DATA_W] = r[SAR_BITS-1:RES_HI_L_LSB];
      v[DATA_W-1:0]        = {r[RES_LO_L_W-1:0], RES_LO_L_W'(0)};
    end
    return v;
  endfunction

  function automatic adcirc_ana_s steer(input adcirc_conv_s c, input adcirc_inclk_s i,
                                         input adcirc_ref_s f, input logic [DATA_W-1:0] b);
    adcirc_ana_s a;
    a = '0;
    a.power_on            = c.enable;
    a.source              = src_decode(i.input_source_select);
    a.ext_chan            = c.channel_select;
    a.ext_chan_connect    = (a.source == SRC_EXT);
    a.reference           = ref_decode(f.reference_source_select);
    a.ref_pin_connect     = (a.reference == REF_PIN);
    a.amp_enable          = f.ref_amplifier_enable;
    a.amp_from_bandgap    = f.amplifier_input_select;
    a.amp_ext_pin_connect = !f.amplifier_input_select;
    a.amp_gain            = f.amplifier_gain_select;
    a.bandgap_enable      = b[0];
    return a;
  endfunction

  // ----------------------------------------------------------------
  // registers and control
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.rdata   = '0;
    s_next.int_req = sar_done;
    if (bus_req.wr) begin
      case (bus_req.addr)
        ADDR_CONV:  s_next.conv  = adcirc_conv_s'(bus_req.wdata & CONV_WMASK);
        ADDR_INCLK: s_next.inclk = adcirc_inclk_s'(bus_req.wdata & INCLK_WMASK);
        ADDR_REF:   s_next.refc  = adcirc_ref_s'(bus_req.wdata & REF_WMASK);
        ADDR_BG:    s_next.bg    = bus_req.wdata & BG_WMASK;
        default:    s_next.bg    = s_reg.bg;
      endcase
    end
    if (bus_req.rd) begin
      case (bus_req.addr)
        ADDR_CONV: begin
          s_next.rdata = s_reg.conv;
          s_next.rdata[DATA_W-2] = sar_busy;
        end
        ADDR_INCLK:  s_next.rdata = s_reg.inclk;
        ADDR_REF:    s_next.rdata = s_reg.refc;
        ADDR_BG:     s_next.rdata = s_reg.bg;
        ADDR_RES_HI: s_next.rdata = s_reg.res_hi;
        ADDR_RES_LO: s_next.rdata = s_reg.res_lo;
        default:     s_next.rdata = '0;
      endcase
    end
    // start bit falling after having been set completes the start sequence
    s_next.start_pulse = s_reg.conv.start && !s_next.conv.start
                         && s_next.conv.enable && !sar_busy;
    if (sar_done) begin
      {s_next.res_hi, s_next.res_lo} = align_result(s_reg.conv.align_right,
                                                    sar_result);
    end
    s_next.ana = steer(s_reg.conv, s_reg.inclk, s_reg.refc, s_reg.bg);
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_reg <= '0;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  assign rd_data      = s_reg.rdata;
  assign ana_ctrl     = s_reg.ana;
  assign conv_int_req = s_reg.int_req;

  // ----------------------------------------------------------------
  // conversion engine
  // ----------------------------------------------------------------
  adcirc_clkdiv u_div (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .run      (sar_busy),
    .div_code (s_reg.inclk.conv_clock_divider),
    .tick     (conv_tick)
  );

  adcirc_sar u_sar (
    .ref_clk     (ref_clk),
    .sys_rst     (sys_rst),
    .clk_en      (clk_en),
    .power_on    (s_reg.conv.enable),
    .start       (s_reg.start_pulse),
    .tick        (conv_tick),
    .cmp_above   (cmp_above),
    .busy        (sar_busy),
    .done        (sar_done),
    .sample_hold (sample_hold),
    .trial       (sar_trial),
    .result      (sar_result)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence start_seq;
    clk_en && s_reg.start_pulse ##1 clk_en;
  endsequence

  power_follows_en_a: assert property (clk_en |=> ana_ctrl.power_on == $past(s_reg.conv.enable))
    else $error("converter power does not follow enable");
  align_result_a: assert property (clk_en && sar_done |=> {s_reg.res_hi, s_reg.res_lo}
      == align_result($past(s_reg.conv.align_right), $past(sar_result)))
    else $error("result bytes misaligned");
  ext_route_a: assert property (clk_en |=> ana_ctrl.ext_chan_connect
      == (src_decode($past(s_reg.inclk.input_source_select)) == SRC_EXT)
      && ana_ctrl.ext_chan == $past(s_reg.conv.channel_select))
    else $error("external channel routing wrong");
  int_disconnect_a: assert property (ana_ctrl.source != SRC_EXT |-> !ana_ctrl.ext_chan_connect)
    else $error("external channel connected with internal source");
  rsvd_read_zero_a: assert property (bus_req.rd && clk_en && bus_req.addr == ADDR_INCLK
      |=> (rd_data & ~INCLK_WMASK) == '0)
    else $error("unimplemented bits read nonzero");
  ref_rsvd_a: assert property (bus_req.rd && clk_en && bus_req.addr == ADDR_REF
      |=> (rd_data & ~REF_WMASK) == '0)
    else $error("reference control reserved bits read nonzero");
  amp_enable_a: assert property (clk_en |=> ana_ctrl.amp_enable
      == $past(s_reg.refc.ref_amplifier_enable)
      && ana_ctrl.amp_gain == $past(s_reg.refc.amplifier_gain_select))
    else $error("amplifier enable or gain not applied");
  amp_pin_off_a: assert property (ana_ctrl.amp_from_bandgap |-> !ana_ctrl.amp_ext_pin_connect)
    else $error("amplifier pin connected while bandgap selected");
  ref_pin_off_a: assert property (ana_ctrl.reference != REF_PIN |-> !ana_ctrl.ref_pin_connect)
    else $error("reference pin connected with internal reference");
  busy_after_start_a: assert property (start_seq |-> sar_busy)
    else $error("busy not set after start sequence");
  done_irq_a: assert property (clk_en && sar_done |=> conv_int_req && !sar_busy)
    else $error("completion did not raise request or left busy");
  bg_read_a: assert property (bus_req.rd && clk_en && bus_req.addr == ADDR_BG
      |=> rd_data == {7'h00, $past(s_reg.bg[0])})
    else $error("bandgap control read wrong");
  amp_input_a: assert property (clk_en |=> ana_ctrl.amp_from_bandgap
      == $past(s_reg.refc.amplifier_input_select))
    else $error("amplifier input select not applied");
  ref_select_a: assert property (clk_en |=> ana_ctrl.reference
      == ref_decode($past(s_reg.refc.reference_source_select)))
    else $error("reference source not applied");
  bandgap_en_a: assert property (clk_en |=> ana_ctrl.bandgap_enable
      == $past(s_reg.bg[0]))
    else $error("bandgap enable not applied");

endmodule
`default_nettype wire

// >>> test/tb_adcirc_top.sv
// tb_adcirc_top: self-checking bench of the converter control block.
// assumes: adcirc_pkg compiled first; the bench drives every port itself.
`timescale 1ns/1ps
`default_nettype none
module tb_adcirc_top;
  import adcirc_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  typedef struct {logic [ADDR_W-1:0] a; logic [DATA_W-1:0] w; logic [DATA_W-1:0] r;} adcirc_row_s;
  logic                ref_clk      = 1'b0;
  logic                sys_rst      = 1'b1;
  logic                clk_en       = 1'b1;
  adcirc_bus_s         bus_req      = '0;
  logic [DATA_W-1:0]   rd_data;
  adcirc_ana_s         ana_ctrl;
  logic                sample_hold;
  logic [SAR_BITS-1:0] sar_trial;
  logic                conv_int_req;
  logic [SAR_BITS-1:0] level        = 12'ha5c;
  logic                cmp_above;
  logic [DATA_W-1:0]   d;
  int                  n;
  int                  n_mismatch   = 0;
  int                  checked      = 0;
  adcirc_row_s         rows [7]     = '{'{3'h1, 8'hff, 8'hf7}, '{3'h2, 8'hff, 8'h9f},
    '{3'h3, 8'hff, 8'h01}, '{3'h3, 8'hfe, 8'h00}, '{3'h6, 8'hff, 8'h00},
    '{3'h0, 8'h5f, 8'h1f}, '{3'h3, 8'h01, 8'h01}};
  adcirc_src_e         exp_src [16] = '{SRC_EXT, SRC_AVDD, SRC_AVDD_2, SRC_AVDD_4, SRC_EXT,
    SRC_VR, SRC_VR_2, SRC_VR_4, SRC_GND, SRC_GND, SRC_GND, SRC_GND,
    SRC_EXT, SRC_EXT, SRC_EXT, SRC_EXT};

  // comparator stand-in: input sits at a fixed level
  assign cmp_above = (level >= sar_trial);
  always #5 ref_clk = ~ref_clk;

  adcirc_top dut (
    .ref_clk      (ref_clk),
    .sys_rst      (sys_rst),
    .clk_en       (clk_en),
    .bus_req      (bus_req),
    .rd_data      (rd_data),
    .cmp_above    (cmp_above),
    .ana_ctrl     (ana_ctrl),
    .sample_hold  (sample_hold),
    .sar_trial    (sar_trial),
    .conv_int_req (conv_int_req)
  );

  // ----------------------------------------------------------------
  // bus cycles and compares
  // ----------------------------------------------------------------
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] w);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req <= '0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_req <= '0;
    #1 d = rd_data;
  endtask

  task automatic settle;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // one conversion: start sequence, busy, timing, result bytes
  task automatic conv(input logic al, input logic [DIV_W-1:0] dv);
    wr(ADDR_INCLK, {5'h00, dv});
    wr(ADDR_CONV, {3'b101, al, 4'h0});
    wr(ADDR_CONV, {3'b001, al, 4'h0});
    rd(ADDR_CONV);
    chk8("busy set", {3'b011, al, 4'h0}, d);
    chk8("sample", 8'h01, 8'(sample_hold));
    n = 0;
    while (conv_int_req !== 1'b1 && n < 4000) begin
      settle();
      n++;
    end
    chk8("conv time", 8'h01, 8'(n >= (12 << dv) && n <= (15 << dv) + 6));
    settle();
    chk8("irq pulse", 8'h00, 8'(conv_int_req));
    rd(ADDR_RES_HI);
    chk8("result hi", al ? {4'h0, level[11:8]} : level[11:4], d);
    rd(ADDR_RES_LO);
    chk8("result lo", al ? level[7:0] : {level[3:0], 4'h0}, d);
    chk8("trial", 8'h01, 8'(sar_trial == level));
    rd(ADDR_CONV);
    chk8("busy clear", {3'b001, al, 4'h0}, d);
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge ref_clk);
    chk8("reset ana", 8'h00, 8'(ana_ctrl != '0));
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(i[2:0]);
      chk8("reset reg", 8'h00, d);
    end
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      chk8("readback", rows[i].r, d);
    end
    chk8("bandgap", 8'h01, 8'(ana_ctrl.bandgap_enable));
    chk8("chan", 8'h0f, 8'(ana_ctrl.ext_chan));
    for (int i = 0; i < 16; i++) begin
      wr(ADDR_INCLK, {i[3:0], 4'h0});
      settle();
      chk8("source", 8'(exp_src[i]), 8'(ana_ctrl.source));
      chk8("chan link", 8'(exp_src[i] == SRC_EXT), 8'(ana_ctrl.ext_chan_connect));
    end
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_REF, {3'b100, k[0], k[1:0], k[1:0]});
      settle();
      chk8("amp ref", {1'b1, k[0], ~k[0], k == 1, k[1:0],
        k[1] ? REF_AMP : (k[0] ? REF_PIN : REF_AVDD)},
        {ana_ctrl.amp_enable, ana_ctrl.amp_from_bandgap, ana_ctrl.amp_ext_pin_connect,
        ana_ctrl.ref_pin_connect, ana_ctrl.amp_gain, ana_ctrl.reference});
    end
    wr(ADDR_REF, 8'h00);
    settle();
    chk8("amp off", 8'h00, 8'(ana_ctrl.amp_enable));
    wr(ADDR_CONV, 8'h80);
    wr(ADDR_CONV, 8'h00);
    rd(ADDR_CONV);
    chk8("no start", 8'h00, d);
    wr(ADDR_CONV, 8'h20);
    settle();
    chk8("power", 8'h01, 8'(ana_ctrl.power_on));
    conv(1'b0, 3'h2);
    conv(1'b1, 3'h0);
    // enable dropped mid-conversion aborts, result bytes kept
    wr(ADDR_CONV, 8'ha0);
    wr(ADDR_CONV, 8'h20);
    wr(ADDR_CONV, 8'h00);
    rd(ADDR_CONV);
    chk8("abort busy", 8'h00, d);
    repeat (20) settle();
    rd(ADDR_RES_LO);
    chk8("abort keep", level[7:0], d);
    // clock enable low freezes the registers
    @(posedge ref_clk);
    clk_en <= 1'b0;
    wr(ADDR_BG, 8'h00);
    clk_en <= 1'b1;
    rd(ADDR_BG);
    chk8("frozen", 8'h01, d);
    // reset in mid-run clears the registers again
    wr(ADDR_REF, 8'h9f);
    sys_rst <= 1'b1;
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(ADDR_REF);
    chk8("rerst reg", 8'h00, d);
    finish_test();
  end

  initial begin
    #500000;
    n_mismatch++;
    finish_test();
  end
endmodule
`default_nettype wire
